/* File: include/uei_pkg.sv */
// Purpose: constants and types of the usb event interrupt unit
// Assumes: register indices are byte addresses divided by four
// Notes:   all control state resets synchronously
// What this block does
// [R1] interrupts leave as short high-then-low pulses
// [R2] wakeup bit or host resume ends suspend
// [R3] resume is followed by a wake pulse
// [R4] event line merges endpoint and bus events
// [R5] clearing a flag re-pulses for next pending
// [R6] mcu clears its latch before source flag
// [R7] vector codes for the five bus events
// [R8] endpoint vectors from 0x18 stepping by four
// [R9] lower vector code wins priority
// [R10] six 32-byte in buffers mapped to mcu
// [R11] six out buffers mapped to mcu
// [R12] iso rx and tx single byte ports
// [R13] iso rx byte count high and low
// [R14] iso crc bit updated at frame start
// [R15] iso zero length bit from previous frame
// [R16] in flags set on ack, write one clears
// [R17] out flags set on good rx, write one clears
// [R18] bus event flags bits 4..0, 7:5 zero
// [R19] write one clears, zero leaves unchanged
// [R20] bus event enable register gates events
// [R21] per-endpoint enables gate endpoint events
`default_nettype none
package uei_pkg;
  // ******************************************************
  // register indices (byte address is index times four)
  // ******************************************************
  localparam logic [15:0] ISO_RX_IDX   = 16'hc760;
  localparam logic [15:0] ISO_TX_IDX   = 16'hc768;
  localparam logic [15:0] ISO_CNTH_IDX = 16'hc770;
  localparam logic [15:0] ISO_CNTL_IDX = 16'hc771;
  localparam logic [15:0] ISO_ERR_IDX  = 16'hc7a0;
  localparam logic [15:0] ISO_ZBC_IDX  = 16'hc7a2;
  localparam logic [15:0] IN_FLG_IDX   = 16'hc7a9;
  localparam logic [15:0] OUT_FLG_IDX  = 16'hc7aa;
  localparam logic [15:0] BUS_FLG_IDX  = 16'hc7ab;
  localparam logic [15:0] IN_IEN_IDX   = 16'hc7ac;
  localparam logic [15:0] OUT_IEN_IDX  = 16'hc7ad;
  localparam logic [15:0] BUS_IEN_IDX  = 16'hc7ae;
  localparam logic [15:0] CTRL_IDX     = 16'hc7f0;
  localparam logic [15:0] VEC_IDX      = 16'hc7f1;
  // ******************************************************
  // buffer windows
  // ******************************************************
  localparam logic [15:0] IN0_BASE  = 16'hc700;
  localparam logic [15:0] OUT0_BASE = 16'hc6c0;
  localparam logic [15:0] BUF_STEP  = 16'h0080;
  localparam int IN_LEN    = 32;
  localparam int OUT_LEN   = 64;
  localparam int EP_N      = 6;
  localparam int MEM_DEPTH = EP_N * (IN_LEN + OUT_LEN);
  // ******************************************************
  // fields, resets, vectors
  // ******************************************************
  localparam int WAKE_BIT = 6;
  localparam int BUS_N    = 5;
  localparam int SRC_N    = BUS_N + 2 * EP_N;
  localparam logic [7:0] VEC_STEP  = 8'h04;
  localparam logic [7:0] VEC_EP0IN = 8'h18;
  localparam logic [7:0] REG_RST   = 8'h00;
  typedef enum logic [2:0] {
    WK_RUN   = 3'b001,
    WK_SUSP  = 3'b010,
    WK_PULSE = 3'b100
  } uei_wake_t;
endpackage
`default_nettype wire

/* File: core/uei_event_irq.sv */
// Purpose: usb event flags, priority vector and mcu interrupt pulses
// Assumes: event inputs come from logic on clk_sys
// Notes:   apb slave answers after one wait state
`default_nettype none
module uei_event_irq
  import uei_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        evSetupData,
  input  wire logic        evFrameStart,
  input  wire logic        evSetupToken,
  input  wire logic        evSuspend,
  input  wire logic        evBusReset,
  input  wire logic [5:0]  inAckDone,
  input  wire logic [5:0]  outRxOk,
  input  wire logic        usbSuspended,
  input  wire logic        hostResume,
  output logic             resumeReq,
  input  wire logic [7:0]  isoRxData,
  output logic             isoRxPop,
  output logic      [7:0]  isoTxData,
  output logic             isoTxPush,
  input  wire logic [15:0] isoCount,
  input  wire logic        isoCrcErr,
  input  wire logic        isoZeroLen,
  output logic             wakePulseLine,
  output logic             usbEventLine
);
  // ******************************************************
  // helper functions
  // ******************************************************
  // buffer window decode: hit flag and flat memory index
  function automatic logic [10:0] bufMap(input logic [15:0] a);
    logic [10:0] r;
    logic [15:0] b;
    r = 11'h0;
    for (int n = 0; n < EP_N; n++) begin
      b = IN0_BASE - BUF_STEP * 16'(n);
      if (a >= b && a < b + 16'(IN_LEN)) begin // [R10]
        r = {1'b1, 10'(n * IN_LEN) + 10'(a - b)};
      end
      b = OUT0_BASE - BUF_STEP * 16'(n);
      if (a >= b && a < b + 16'(OUT_LEN)) begin // [R11]
        r = {1'b1, 10'(EP_N * IN_LEN + n * OUT_LEN) + 10'(a - b)};
      end
    end
    return r;
  endfunction
  // lowest pending index wins
  function automatic logic [4:0] prio(input logic [SRC_N-1:0] p);
    logic [4:0] r;
    r = 5'h0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (p[i]) begin // [R9]
        r = 5'(i);
      end
    end
    return r;
  endfunction
  // vector code for a source index
  function automatic logic [7:0] vecCode(input logic [4:0] i);
    logic [7:0] r;
    if (i < 5'(BUS_N)) begin
      r = VEC_STEP * 8'(i); // [R7]
    end else begin
      r = VEC_EP0IN + VEC_STEP * 8'(i - 5'(BUS_N)); // [R8]
    end
    return r;
  endfunction
  // ******************************************************
  // apb handshake
  // ******************************************************
  logic        rdy;          // access phase answered
  logic        errq;         // unmapped address seen
  logic        commit;       // transfer completes now
  logic        wr;           // write takes effect
  logic        rd;           // read completes
  logic [15:0] idx;          // register index
  logic [10:0] bmap;         // buffer decode result
  logic [7:0]  rdMux;        // selected read byte
  logic        mapped;       // index is decoded
  assign idx    = paddr[17:2];
  assign bmap   = bufMap(idx);
  assign commit = psel & penable & rdy;
  assign wr     = commit & pwrite;
  assign rd     = commit & ~pwrite;
  assign pready = rdy;
  assign pslverr = rdy & errq;
  // one wait state lets read data come from a flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdy <= 1'b0;
    end else begin
      rdy <= psel & penable & ~rdy;
    end
  end
  // ******************************************************
  // registers written by software
  // ******************************************************
  logic [5:0]  inIen;        // in endpoint enables
  logic [5:0]  outIen;       // out endpoint enables
  logic [4:0]  busIen;       // bus event enables
  logic        wakeBit;      // software wakeup request
  logic [7:0]  bufMem [MEM_DEPTH]; // bulk buffers
  uei_wake_t   wakeSt;       // suspend tracking state
  logic        leaveSusp;    // resume condition met
  assign leaveSusp = (wakeSt == WK_SUSP) & (wakeBit | hostResume);
  // enables, reserved bits dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inIen  <= 6'h00;
      outIen <= 6'h00;
      busIen <= 5'h00;
    end else if (wr) begin
      if (idx == IN_IEN_IDX) begin
        inIen <= pwdata[5:0]; // [R21]
      end
      if (idx == OUT_IEN_IDX) begin
        outIen <= pwdata[5:0]; // [R21]
      end
      if (idx == BUS_IEN_IDX) begin
        busIen <= pwdata[4:0]; // [R20]
      end
    end
  end
  // wakeup bit: hardware drops it once resume is issued
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wakeBit <= 1'b0;
    end else if (leaveSusp) begin
      wakeBit <= 1'b0;
    end else if (wr && idx == CTRL_IDX) begin
      wakeBit <= pwdata[WAKE_BIT]; // [R2]
    end
  end
  // buffer storage, no reset: contents are data, not control
  always_ff @(posedge clk_sys) begin
    if (wr && bmap[10]) begin
      bufMem[bmap[9:0]] <= pwdata[7:0]; // [R10]
    end
  end
  // iso tx byte port: push pulse with held byte
  assign isoTxPush = wr & (idx == ISO_TX_IDX); // [R12]
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      isoTxData <= REG_RST;
    end else if (wr && idx == ISO_TX_IDX) begin
      isoTxData <= pwdata[7:0];
    end
  end
  // iso rx pop when the read completes
  assign isoRxPop = rd & (idx == ISO_RX_IDX); // [R12]
  // ******************************************************
  // iso status sampled at frame start
  // ******************************************************
  logic isoErr;  // crc error of last frame
  logic isoZbc;  // zero length packet last frame
  // data stays readable even when crc failed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      isoErr <= 1'b0;
      isoZbc <= 1'b0;
    end else if (evFrameStart) begin
      isoErr <= isoCrcErr;  // [R14]
      isoZbc <= isoZeroLen; // [R15]
    end
  end
  // ******************************************************
  // event flags, set wins over clear
  // ******************************************************
  logic [5:0] inFlg;   // in endpoint acked
  logic [5:0] outFlg;  // out endpoint received
  logic [4:0] busFlg;  // bus events
  logic [4:0] busSet;  // bus event set terms
  logic [5:0] inClr;   // in clear mask
  logic [5:0] outClr;  // out clear mask
  logic [4:0] busClr;  // bus clear mask
  assign busSet = {evBusReset, evSuspend, evSetupToken,
                   evFrameStart, evSetupData}; // [R18]
  assign inClr  = (wr && idx == IN_FLG_IDX) ? pwdata[5:0] : 6'h00;
  assign outClr = (wr && idx == OUT_FLG_IDX) ? pwdata[5:0] : 6'h00;
  assign busClr = (wr && idx == BUS_FLG_IDX) ? pwdata[4:0] : 5'h00;
  // writing zero keeps a bit, a one clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inFlg  <= 6'h00;
      outFlg <= 6'h00;
      busFlg <= 5'h00;
    end else begin
      inFlg  <= (inFlg & ~inClr) | inAckDone;   // [R16]
      outFlg <= (outFlg & ~outClr) | outRxOk;   // [R17]
      busFlg <= (busFlg & ~busClr) | busSet;    // [R19]
    end
  end
  // ******************************************************
  // priority and vector
  // ******************************************************
  logic [SRC_N-1:0] pend;   // enabled pending sources
  logic             anyPend;
  logic [7:0]       vecReg; // code of active source
  // interleave in/out per endpoint after bus events
  always_comb begin
    pend = '0;
    pend[BUS_N-1:0] = busFlg & busIen; // [R20]
    for (int n = 0; n < EP_N; n++) begin
      pend[BUS_N + 2*n]     = inFlg[n] & inIen[n];   // [R21]
      pend[BUS_N + 2*n + 1] = outFlg[n] & outIen[n]; // [R21]
    end
  end
  assign anyPend = |pend; // [R4]
  // vector holds its last value when nothing pends
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vecReg <= REG_RST;
    end else if (anyPend) begin
      vecReg <= vecCode(prio(pend)); // [R7]
    end
  end
  // ******************************************************
  // event line pulse generation
  // ******************************************************
  logic prevAny;  // anything pending last cycle
  logic clrEvt;   // a pending flag was cleared
  logic trigReq;  // pulse owed to the mcu
  logic emit;     // raise the line next cycle
  // a pulse needs a low cycle first, so owed pulses wait
  assign emit = trigReq & ~usbEventLine & anyPend;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prevAny <= 1'b0;
      clrEvt  <= 1'b0;
      trigReq <= 1'b0;
      usbEventLine <= 1'b0;
    end else begin
      prevAny <= anyPend;
      clrEvt  <= |{busClr & busFlg, inClr & inFlg, outClr & outFlg};
      trigReq <= (trigReq | (anyPend & ~prevAny)
                 | (clrEvt & anyPend)) & ~emit & anyPend; // [R5]
      usbEventLine <= emit; // [R1]
    end
  end
  // ******************************************************
  // suspend and wake
  // ******************************************************
  assign resumeReq = leaveSusp; // [R2]
  // wake pulse lasts the single pulse state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wakeSt <= WK_RUN;
    end else begin
      case (wakeSt)
        WK_RUN: begin
          if (usbSuspended) begin
            wakeSt <= WK_SUSP;
          end
        end
        WK_SUSP: begin
          if (leaveSusp) begin
            wakeSt <= WK_PULSE; // [R3]
          end
        end
        WK_PULSE: begin
          wakeSt <= WK_RUN;
        end
        default: begin
          wakeSt <= WK_RUN;
        end
      endcase
    end
  end
  assign wakePulseLine = (wakeSt == WK_PULSE); // [R1]
  // ******************************************************
  // read mux and answer
  // ******************************************************
  always_comb begin
    rdMux  = REG_RST;
    mapped = 1'b1;
    case (idx)
      ISO_RX_IDX:   rdMux = isoRxData;
      ISO_TX_IDX:   rdMux = REG_RST;
      ISO_CNTH_IDX: rdMux = isoCount[15:8]; // [R13]
      ISO_CNTL_IDX: rdMux = isoCount[7:0];  // [R13]
      ISO_ERR_IDX:  rdMux = {7'h00, isoErr};
      ISO_ZBC_IDX:  rdMux = {7'h00, isoZbc};
      IN_FLG_IDX:   rdMux = {2'h0, inFlg};
      OUT_FLG_IDX:  rdMux = {2'h0, outFlg};
      BUS_FLG_IDX:  rdMux = {3'h0, busFlg}; // [R18]
      IN_IEN_IDX:   rdMux = {2'h0, inIen};
      OUT_IEN_IDX:  rdMux = {2'h0, outIen};
      BUS_IEN_IDX:  rdMux = {3'h0, busIen};
      CTRL_IDX:     rdMux = {1'b0, wakeBit, 6'h00};
      VEC_IDX:      rdMux = vecReg;
      default: begin
        if (bmap[10]) begin
          rdMux = bufMem[bmap[9:0]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end
  // data captured in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      errq   <= 1'b0;
    end else if (psel && penable && !rdy) begin
      prdata <= {24'h00_0000, rdMux};
      errq   <= ~mapped;
    end
  end
  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_evt_pulse;
    usbEventLine |=> !usbEventLine;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) // [R1]
    else $error("event line high two cycles");
  property p_wake_pulse;
    wakePulseLine |=> !wakePulseLine;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) // [R1]
    else $error("wake line high two cycles");
  sequence s_resume;
    resumeReq;
  endsequence
  property p_wake_after;
    s_resume |=> wakePulseLine;
  endproperty
  a_wake_after: assert property (p_wake_after) // [R3]
    else $error("no wake pulse after resume");
  property p_resume_cause;
    (wakeSt == WK_SUSP && hostResume) |=> wakePulseLine && !wakeBit;
  endproperty
  a_resume_cause: assert property (p_resume_cause) // [R2]
    else $error("host resume ignored");
  property p_evt_src;
    usbEventLine |-> $past(anyPend);
  endproperty
  a_evt_src: assert property (p_evt_src) // [R4]
    else $error("event pulse with nothing pending");
  sequence s_clr_left;
    clrEvt && anyPend ##1 anyPend[*2];
  endsequence
  property p_repulse;
    s_clr_left |-> ##[0:1] usbEventLine;
  endproperty
  a_repulse: assert property (p_repulse) // [R5]
    else $error("no pulse after clearing one flag");
  property p_vec;
    (anyPend && pend[BUS_N-1:0] != 5'h00) |=> vecReg < VEC_EP0IN;
  endproperty
  a_vec: assert property (p_vec) // [R7]
    else $error("vector wrong");
  property p_vec_ep;
    (anyPend && pend[BUS_N-1:0] == 5'h00) |=> vecReg >= VEC_EP0IN;
  endproperty
  a_vec_ep: assert property (p_vec_ep) // [R8]
    else $error("endpoint vector below range");
  property p_sof;
    evFrameStart |=> isoErr == $past(isoCrcErr);
  endproperty
  a_sof: assert property (p_sof) // [R14]
    else $error("crc bit not taken at frame start");
  property p_w1c;
    (wr && idx == BUS_FLG_IDX && pwdata[0] && !evSetupData) |=> !busFlg[0];
  endproperty
  a_w1c: assert property (p_w1c) // [R19]
    else $error("write one did not clear");
endmodule
`default_nettype wire

/* File: tb/uei_mcu_model.sv */
// Purpose: mcu side of the event unit, edge-triggered interrupt inputs
// Assumes: both interrupt lines are synchronous to clk_sys
// Notes:   the bench clears the event latch the way firmware would
`default_nettype none
module uei_mcu_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       wakePulseLine,
  input  wire logic       usbEventLine,
  input  wire logic       clrEvt,
  output logic            evtLatch,
  output logic      [7:0] evtCount,
  output logic      [7:0] wakeCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prevEvt;   // event line one cycle ago
  logic prevWake;  // wake line one cycle ago
  // only a low-to-high step counts, a held line is not a new request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prevEvt   <= 1'b0;
      prevWake  <= 1'b0;
      evtLatch  <= 1'b0;
      evtCount  <= 8'h00;
      wakeCount <= 8'h00;
    end else begin
      prevEvt  <= usbEventLine;
      prevWake <= wakePulseLine;
      if (wakePulseLine && !prevWake) begin
        wakeCount <= wakeCount + 8'h01;
      end
      // latch first cleared here, source flag later by the bench
      if (usbEventLine && !prevEvt) begin
        evtLatch <= 1'b1;
        evtCount <= evtCount + 8'h01;
      end else if (clrEvt) begin
        evtLatch <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/usb_event_irq_unit_tb.sv */
// Purpose: self-checking bench of the usb event interrupt unit
// Assumes: apb answers with pready, bench waits without a fixed count
// Notes:   source bit i: 0..4 bus events, then ep0in, ep0out .. ep5out
`default_nettype none
module usb_event_irq_unit_tb
  import uei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // signals
  // ********
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [16:0] src;  // one-cycle event pulses
  logic        usbSuspended, hostResume, resumeReq, isoRxPop, isoTxPush;
  logic [7:0]  isoRxData, isoTxData, evtCount, wakeCount, rd;
  logic [15:0] isoCount;
  logic        isoCrcErr, isoZeroLen, wakePulseLine, usbEventLine;
  logic        clrEvt, evtLatch, sawPop, sawPush, sawRes, lastErr;
  int          n_errors, n_tests, base;
  // expected vector of each source row
  logic [7:0]  vecTab [17] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18,
    8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
  int          ord [3] = '{3, 7, 16};  // suspend, ep1in, ep5out
  logic [15:0] bufA [4] = '{16'hc700, 16'hc49f, 16'hc6c0, 16'hc47f};

  uei_event_irq DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evSetupData(src[0]), .evFrameStart(src[1]),
    .evSetupToken(src[2]), .evSuspend(src[3]), .evBusReset(src[4]),
    .inAckDone({src[15], src[13], src[11], src[9], src[7], src[5]}),
    .outRxOk({src[16], src[14], src[12], src[10], src[8], src[6]}),
    .usbSuspended(usbSuspended), .hostResume(hostResume), .resumeReq(resumeReq),
    .isoRxData(isoRxData), .isoRxPop(isoRxPop), .isoTxData(isoTxData),
    .isoTxPush(isoTxPush), .isoCount(isoCount), .isoCrcErr(isoCrcErr),
    .isoZeroLen(isoZeroLen), .wakePulseLine(wakePulseLine),
    .usbEventLine(usbEventLine));
  uei_mcu_model MCU (.clk_sys(clk_sys), .rst_n(rst_n), .wakePulseLine(wakePulseLine),
    .usbEventLine(usbEventLine), .clrEvt(clrEvt), .evtLatch(evtLatch),
    .evtCount(evtCount), .wakeCount(wakeCount));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // iso strobes are single-cycle, so remember that they fired
  always @(posedge clk_sys) begin
    if (isoRxPop === 1'b1) sawPop <= 1'b1;
    if (isoTxPush === 1'b1) sawPush <= 1'b1;
    if (resumeReq === 1'b1) sawRes <= 1'b1;
  end
  // ********
  // tasks
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // no fixed wait count: only the watchdog ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd      = prdata[7:0];
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [16:0] m);
    @(posedge clk_sys);
    src <= m;
    @(posedge clk_sys);
    src <= '0;
  endtask
  // bounded wait on a pulse count seen by the mcu model
  task automatic waitCnt(input bit wake, input int n);
    int k;
    k = 0;
    while ((wake ? wakeCount : evtCount) !== 8'(n) && k < 30) begin
      @(posedge clk_sys);
      k++;
    end
    chk(wake ? wakeCount : evtCount, 16'(n));
  endtask
  function automatic logic [15:0] flagIdx(input int i);
    return (i < 5) ? BUS_FLG_IDX : ((i % 2) ? IN_FLG_IDX : OUT_FLG_IDX);
  endfunction
  function automatic logic [7:0] flagBit(input int i);
    return (i < 5) ? 8'(1 << i) : 8'(1 << ((i - 5) / 2));
  endfunction
  // firmware order: own latch first, then the source flag
  task automatic service(input int i);
    @(posedge clk_sys);
    clrEvt <= 1'b1;
    @(posedge clk_sys);
    clrEvt <= 1'b0;
    @(posedge clk_sys);
    chk(evtLatch, 1'b0);
    apb(1'b1, flagIdx(i), flagBit(i));
  endtask
  // ********
  // sequence
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata, src, usbSuspended, hostResume} = '0;
    {isoRxData, isoCount, isoCrcErr, isoZeroLen, clrEvt, sawPop, sawPush, sawRes} = '0;
    rst_n = 1'b0;
    n_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(BUS_FLG_IDX, 8'h00);
    rdchk(VEC_IDX, 8'h00);
    apb(1'b1, BUS_IEN_IDX, 8'h1f);
    apb(1'b1, IN_IEN_IDX, 8'h3f);
    apb(1'b1, OUT_IEN_IDX, 8'h3f);
    // one row per source: pulse, vector, flag, clear
    for (int i = 0; i < 17; i++) begin
      pulse(17'h1 << i);
      waitCnt(1'b0, i + 1);
      rdchk(VEC_IDX, vecTab[i]);
      rdchk(flagIdx(i), flagBit(i));
      service(i);
      rdchk(flagIdx(i), 8'h00);
    end
    // three at once come out one by one, lowest code first
    base = evtCount;
    pulse(17'h10088);
    for (int j = 0; j < 3; j++) begin
      waitCnt(1'b0, base + j + 1);
      rdchk(VEC_IDX, vecTab[ord[j]]);
      service(ord[j]);
    end
    repeat (10) @(posedge clk_sys);
    chk(evtCount, 16'(base + 3));
    // masked sources set flags but raise nothing
    apb(1'b1, BUS_IEN_IDX, 8'h1d);
    apb(1'b1, IN_IEN_IDX, 8'h00);
    apb(1'b1, OUT_IEN_IDX, 8'h00);
    base = evtCount;
    pulse(17'h00062);
    repeat (10) @(posedge clk_sys);
    chk(evtCount, 16'(base));
    apb(1'b1, BUS_FLG_IDX, 8'hfd);
    rdchk(BUS_FLG_IDX, 8'h02);
    apb(1'b1, BUS_FLG_IDX, 8'h02);
    rdchk(BUS_FLG_IDX, 8'h00);
    rdchk(IN_FLG_IDX, 8'h01);
    rdchk(OUT_FLG_IDX, 8'h01);
    apb(1'b1, IN_FLG_IDX, 8'h01);
    apb(1'b1, OUT_FLG_IDX, 8'h01);
    // wake by control bit, then by host resume
    usbSuspended <= 1'b1;
    base = wakeCount;
    apb(1'b1, CTRL_IDX, 8'h40);
    waitCnt(1'b1, base + 1);
    chk(sawRes, 1'b1);
    rdchk(CTRL_IDX, 8'h00);
    @(posedge clk_sys);
    hostResume <= 1'b1;
    @(posedge clk_sys);
    hostResume <= 1'b0;
    waitCnt(1'b1, base + 2);
    usbSuspended <= 1'b0;
    // iso ports, count, frame-sampled status
    isoCount <= 16'h1234;
    isoRxData <= 8'ha5;
    isoCrcErr <= 1'b1;
    isoZeroLen <= 1'b1;
    rdchk(ISO_ERR_IDX, 8'h00);
    rdchk(ISO_CNTH_IDX, 8'h12);
    rdchk(ISO_CNTL_IDX, 8'h34);
    rdchk(ISO_RX_IDX, 8'ha5);
    apb(1'b1, ISO_TX_IDX, 8'h5a);
    // byte and push land at the commit edge, so look one edge later
    @(posedge clk_sys);
    chk({sawPop, sawPush, isoTxData}, 16'h035a);
    pulse(17'h2);
    rdchk(ISO_ERR_IDX, 8'h01);
    rdchk(ISO_ZBC_IDX, 8'h01);
    isoCrcErr <= 1'b0;
    isoZeroLen <= 1'b0;
    pulse(17'h2);
    rdchk(ISO_ERR_IDX, 8'h00);
    rdchk(ISO_ZBC_IDX, 8'h00);
    // buffer edges, then an unmapped index
    foreach (bufA[b]) apb(1'b1, bufA[b], 8'h3c + 8'(b));
    foreach (bufA[b]) rdchk(bufA[b], 8'h3c + 8'(b));
    rdchk(16'hc7fe, 8'h00);
    chk(lastErr, 1'b1);
    // reset in mid-run wipes flags, enables and the vector
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(BUS_FLG_IDX, 8'h00);
    rdchk(BUS_IEN_IDX, 8'h00);
    rdchk(VEC_IDX, 8'h00);
    end_of_test();
  end
  // watchdog well beyond the expected several hundred cycles
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
